// *** ltcr_reader.sv ***
// biphase time code reader: bit recovery, word assembly, address check
// and an output fifo of checked words
// assumes code_in is a squared comparator output, asynchronous to clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "ltcr_defines.svh"

// ****************************************
// output fifo
// ****************************************
module ltcr_fifo #(
    parameter int WIDTH = `LTCR_FIFO_WIDTH,
    parameter int DEPTH = `LTCR_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // fill side
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    // drain side
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             ov_q, ov_d;
    logic [WIDTH-1:0] od_q, od_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = ov_q;
    assign out_data  = od_q;

    // head register keeps the drain side straight off flip-flops
    always_comb begin
        push = in_valid && in_ready;
        pop  = (cnt_q != '0) && (!ov_q || out_ready);
        wr_d = push ? wr_q + 1'b1 : wr_q;
        rd_d = pop ? rd_q + 1'b1 : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
        od_d = pop ? mem_q[rd_q] : od_q;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            ov_q  <= 1'b0;
            od_q  <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            ov_q  <= ov_d;
            od_q  <= od_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // ltcr_fifo

// ****************************************
// reader top
// ****************************************
// Notes on behaviour
// [R1] bit length timed between input zero crossings
// [R2] two half-length periods make one, else zero
// [R3] decodes from tenth play speed to thirty times
// [R4] timing copes with 72 kHz zeros, 144 kHz ones
// [R5] stopped tape yields no words
// [R6] bits assembled into eighty-bit words
// [R7] valid words advance one frame each
// [R8] sync bits give the incoming code speed
// [R9] forward and reverse motion both decode
// [R10] isolated non-contiguous addresses are discarded
// [R11] bad words: position keeps advancing from last
// [R12] sustained jump accepted; locked error follows
// [R13] one has mid-bit reversal, zero none
// [R14] eight bcd address groups, eight user groups
// [R15] sync ends word; 00 forward, 01 reverse
// [R16] jump taken after three contiguous followers
// [R17] one-cycle valid strobe; reject pulse per discard
module ltcr_reader
    import ltcr_pkg::*;
#(
    parameter int STALL_CYC = `LTCR_STALL_CYC
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // squared time code from the tape track
    input  wire logic                 code_in,
    // lock state and master position from the synchroniser
    input  wire logic                 lock_in,
    input  wire ltcr_pkg::ltcr_frames_t ref_frames,
    // checked position and status
    output logic                      word_strobe_q,
    output logic                      word_reject_q,
    output ltcr_pkg::ltcr_frames_t    pos_frames_q,
    output logic                      pos_valid_q,
    output logic                      reverse_q,
    output logic               [24:0] tc_error_q,
    output logic               [23:0] word_cycles_q,
    output logic                      code_active_q,
    output logic                      overrun_q,
    // checked words: user bits high, bcd address low
    output logic                      word_valid,
    output logic               [63:0] word_data,
    input  wire logic                 word_ready
);
    import ltcr_pkg::*;

    localparam int CW = 24;

    function automatic logic [31:0] bcd_addr(input logic [63:0] d);
        return {2'h0, d[57:56], d[51:48], 1'b0, d[42:40], d[35:32],
                1'b0, d[26:24], d[19:16], 2'h0, d[9:8], d[3:0]}; // R14
    endfunction

    function automatic logic [31:0] user_bits(input logic [63:0] d);
        return {d[63:60], d[55:52], d[47:44], d[39:36],
                d[31:28], d[23:20], d[15:12], d[7:4]}; // R14
    endfunction

    function automatic ltcr_frames_t to_frames(input logic [31:0] a);
        int t;
        t = (int'(a[31:28]) * 10 + int'(a[27:24])) * 60;
        t = (t + int'(a[23:20]) * 10 + int'(a[19:16])) * 60;
        t = (t + int'(a[15:12]) * 10 + int'(a[11:8])) * `LTCR_FPS;
        t = t + int'(a[7:4]) * 10 + int'(a[3:0]);
        return t[23:0];
    endfunction

    function automatic ltcr_frames_t step(input ltcr_frames_t f,
                                          input logic rev);
        return rev ? f - 24'h000001 : f + 24'h000001;
    endfunction

    // ****************************************
    // input synchroniser and bit recovery
    // ****************************************
    logic [2:0]  sy_q, sy_d;
    logic        lvl_q, lvl_d, half_q, half_d, act_q, act_d;
    logic [CW-1:0] cnt_q, cnt_d, per_q, per_d, hiv_q, hiv_d;
    logic [CW-1:0] wcy_q, wcy_d, wcyo_q, wcyo_d;
    logic [79:0] sr_q, sr_d;
    logic [6:0]  nb_q, nb_d;
    logic        wev_q, wev_d, wrev_q, wrev_d;
    logic [63:0] wdat_q, wdat_d;
    logic        edge_seen, bit_ev, bit_val;
    logic [CW-1:0] iv;
    logic [CW+1:0] iv4, per3;

    always_comb begin
        sy_d   = {sy_q[1:0], code_in};
        lvl_d  = lvl_q;
        cnt_d  = cnt_q;
        per_d  = per_q;
        hiv_d  = hiv_q;
        half_d = half_q;
        act_d  = act_q;
        sr_d   = sr_q;
        nb_d   = nb_q;
        wev_d  = 1'b0;
        wrev_d = wrev_q;
        wdat_d = wdat_q;
        wcy_d  = (wcy_q == '1) ? wcy_q : wcy_q + 1'b1;
        wcyo_d = wcyo_q;
        bit_ev = 1'b0;
        bit_val = 1'b0;
        iv   = cnt_q + 1'b1;
        iv4  = {iv, 2'b00};
        per3 = {2'b00, per_q} + {1'b0, per_q, 1'b0};
        // a level counts once the second and third stages agree
        edge_seen = (sy_q[1] == sy_q[2]) && (sy_q[2] != lvl_q)
                    && (iv >= CW'(`LTCR_GLITCH_CYC)); // R4
        if (edge_seen) begin
            lvl_d = sy_q[2];
            cnt_d = '0;
            act_d = 1'b1;
            if (iv4 < per3) begin // R2
                // two short periods in a row: mid-bit reversal
                if (half_q) begin // R13
                    bit_ev  = 1'b1;
                    bit_val = 1'b1;
                    half_d  = 1'b0;
                    per_d   = hiv_q + iv; // R3
                end else begin
                    half_d = 1'b1;
                    hiv_d  = iv;
                end
            end else begin
                // a lone half before a full period is a slip: drop it
                bit_ev = 1'b1;
                half_d = 1'b0;
                per_d  = iv; // R1
            end
        end else if (cnt_q >= CW'(STALL_CYC)) begin
            // no edges on a stopped tape: abandon the word in flight
            act_d  = 1'b0; // R5
            half_d = 1'b0;
            nb_d   = '0;
            per_d  = `LTCR_PER_INIT;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
        if (bit_ev) begin
            sr_d = {bit_val, sr_q[79:1]}; // R6
            nb_d = (nb_q == 7'h7f) ? nb_q : nb_q + 1'b1;
            if (sr_d[79:64] == `LTCR_SYNC_FWD ||
                sr_d[79:64] == `LTCR_SYNC_REV) begin // R15
                nb_d   = '0;
                wcy_d  = '0;
                wcyo_d = wcy_q; // R8
                if (nb_q == 7'(`LTCR_WORD_BITS - 1)) begin
                    wev_d  = 1'b1;
                    wrev_d = (sr_d[79:64] == `LTCR_SYNC_REV); // R9
                    for (int i = 0; i < 64; i++) begin
                        wdat_d[i] = wrev_d ? sr_d[63-i] : sr_d[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sy_q   <= '0;
            lvl_q  <= 1'b0;
            cnt_q  <= '0;
            per_q  <= `LTCR_PER_INIT;
            hiv_q  <= '0;
            half_q <= 1'b0;
            act_q  <= 1'b0;
            sr_q   <= '0;
            nb_q   <= '0;
            wev_q  <= 1'b0;
            wrev_q <= 1'b0;
            wdat_q <= '0;
            wcy_q  <= '0;
            wcyo_q <= '0;
        end else begin
            sy_q   <= sy_d;
            lvl_q  <= lvl_d;
            cnt_q  <= cnt_d;
            per_q  <= per_d;
            hiv_q  <= hiv_d;
            half_q <= half_d;
            act_q  <= act_d;
            sr_q   <= sr_d;
            nb_q   <= nb_d;
            wev_q  <= wev_d;
            wrev_q <= wrev_d;
            wdat_q <= wdat_d;
            wcy_q  <= wcy_d;
            wcyo_q <= wcyo_d;
        end
    end

    // ****************************************
    // address check
    // ****************************************
    ltcr_chk_t    st_q, st_d;
    ltcr_frames_t pos_q, pos_d, cand_q, cand_d, f;
    logic [1:0]   run_q, run_d;
    logic         cv_q, cv_d, stb_q, stb_d, rej_q, rej_d, rev_q, rev_d;
    logic [24:0]  err_q, err_d;
    logic         hold_q, hold_d, ovr_q, ovr_d, fin_ready, take;
    logic [63:0]  hdat_q, hdat_d;

    always_comb begin
        st_d   = st_q;
        pos_d  = pos_q;
        cand_d = cand_q;
        run_d  = run_q;
        cv_d   = cv_q;
        stb_d  = 1'b0;
        rej_d  = 1'b0;
        rev_d  = rev_q;
        err_d  = err_q;
        ovr_d  = ovr_q;
        take   = 1'b0;
        hold_d = hold_q && !fin_ready;
        hdat_d = hdat_q;
        f = to_frames(bcd_addr(wdat_q));
        if (wev_q) begin
            rev_d = wrev_q;
            if (st_q == CHK_TRACK && f == step(pos_q, wrev_q)) begin
                take = 1'b1; // R7
                cv_d = 1'b0;
            end else begin
                rej_d = 1'b1; // R10
                if (st_q == CHK_TRACK) begin
                    pos_d = step(pos_q, wrev_q); // R11
                end
                if (cv_q && f == step(cand_q, wrev_q)) begin
                    run_d = run_q + 1'b1;
                    if (run_q == 2'(`LTCR_JUMP_RUN - 1)) begin
                        take  = 1'b1; // R16
                        rej_d = 1'b0;
                        cv_d  = 1'b0;
                        st_d  = CHK_TRACK;
                    end
                end else begin
                    run_d = '0;
                    cv_d  = 1'b1;
                end
                cand_d = f;
            end
            if (take) begin
                pos_d = f; // R12
                stb_d = 1'b1; // R17
                if (lock_in) begin
                    err_d = {1'b0, f} - {1'b0, ref_frames}; // R12
                end
                // one word of slack; a second behind a full fifo is lost
                if (hold_q && !fin_ready) begin
                    ovr_d = 1'b1;
                end else begin
                    hold_d = 1'b1;
                    hdat_d = {user_bits(wdat_q), bcd_addr(wdat_q)};
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q   <= CHK_SEEK;
            pos_q  <= '0;
            cand_q <= '0;
            run_q  <= '0;
            cv_q   <= 1'b0;
            stb_q  <= 1'b0;
            rej_q  <= 1'b0;
            rev_q  <= 1'b0;
            err_q  <= '0;
            hold_q <= 1'b0;
            hdat_q <= '0;
            ovr_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            pos_q  <= pos_d;
            cand_q <= cand_d;
            run_q  <= run_d;
            cv_q   <= cv_d;
            stb_q  <= stb_d;
            rej_q  <= rej_d;
            rev_q  <= rev_d;
            err_q  <= err_d;
            hold_q <= hold_d;
            hdat_q <= hdat_d;
            ovr_q  <= ovr_d;
        end
    end

    ltcr_fifo #(
        .WIDTH (64),
        .DEPTH (`LTCR_FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .in_valid  (hold_q),
        .in_data   (hdat_q),
        .in_ready  (fin_ready),
        .out_valid (word_valid),
        .out_data  (word_data),
        .out_ready (word_ready)
    );

    assign word_strobe_q = stb_q;
    assign word_reject_q = rej_q;
    assign pos_frames_q  = pos_q;
    assign pos_valid_q   = (st_q == CHK_TRACK);
    assign reverse_q     = rev_q;
    assign tc_error_q    = err_q;
    assign word_cycles_q = wcyo_q;
    assign code_active_q = act_q;
    assign overrun_q     = ovr_q;
endmodule // ltcr_reader

`default_nettype wire

// *** ltcr_defines.svh ***
// constants for the longitudinal time code reader: word layout, sync
// patterns, speed range and derived cycle counts
// assumes a 25 MHz system clock
`ifndef LTCR_DEFINES_SVH
`define LTCR_DEFINES_SVH

// ****************************************
// clock and speed range
// ****************************************
`define LTCR_CLK_HZ        25000000
`define LTCR_PLAY_BIT_HZ   2400
`define LTCR_MIN_SPEED_DIV 10
`define LTCR_MAX_ZERO_HZ   72000
`define LTCR_MAX_ONE_HZ    144000
// shortest legal full bit at top wind speed
`define LTCR_MIN_FULL_CYC  (`LTCR_CLK_HZ / `LTCR_MAX_ZERO_HZ)
// edges closer than a quarter of the fastest half-bit are noise
`define LTCR_GLITCH_CYC    (`LTCR_CLK_HZ / (4 * `LTCR_MAX_ONE_HZ))
// no edge for two slowest bit periods: tape treated as stopped
`define LTCR_STALL_CYC     (`LTCR_CLK_HZ * `LTCR_MIN_SPEED_DIV * 2 \
                            / `LTCR_PLAY_BIT_HZ)
`define LTCR_PER_INIT      24'h000400

// ****************************************
// word layout
// ****************************************
`define LTCR_WORD_BITS     80
`define LTCR_SYNC_FWD      16'hbffc
`define LTCR_SYNC_REV      16'h3ffd
`define LTCR_FPS           30
`define LTCR_JUMP_RUN      3
`define LTCR_FIFO_DEPTH    16
`define LTCR_FIFO_WIDTH    64

`endif

// *** ltcr_pkg.sv ***
// types shared by the time code reader
// assumes ltcr_defines.svh for numeric constants
`default_nettype none
package ltcr_pkg;
    typedef enum logic [0:0] {CHK_SEEK, CHK_TRACK} ltcr_chk_t;
    typedef logic [23:0] ltcr_frames_t;
endpackage
`default_nettype wire

// *** ltcr_reader_assertions.sv ***
// concurrent checks on the ports of the time code reader top
// assumes one clock domain and the async active-low reset of the top
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// reader checker
// ****************************************
module ltcr_reader_chk
    import ltcr_pkg::*;
#(
    parameter int STALL_CYC = 2000
) (
    // clock and reset
    input wire logic                   clk_sys,
    input wire logic                   rst_n,
    // code and synchroniser side
    input wire logic                   code_in,
    input wire logic                   lock_in,
    input wire ltcr_pkg::ltcr_frames_t ref_frames,
    // position and status
    input wire logic                   word_strobe_q,
    input wire logic                   word_reject_q,
    input wire ltcr_pkg::ltcr_frames_t pos_frames_q,
    input wire logic                   pos_valid_q,
    input wire logic            [24:0] tc_error_q,
    input wire logic                   code_active_q,
    input wire logic                   overrun_q,
    // word stream
    input wire logic                   word_valid,
    input wire logic            [63:0] word_data,
    input wire logic                   word_ready
);
    logic [23:0] idle_q;
    logic [23:0] idle_d;
    logic        prev_q;
    // saturates so a long stop never wraps back to a small count
    always_comb begin
        idle_d = (idle_q == 24'hffffff) ? idle_q : idle_q + 24'h000001;
        if (code_in != prev_q) idle_d = 24'h000000;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            idle_q <= 24'h000000;
            prev_q <= 1'b0;
        end else begin
            idle_q <= idle_d;
            prev_q <= code_in;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence word_pulse;
        word_strobe_q || word_reject_q;
    endsequence
    sequence quiet8;
        !(word_strobe_q || word_reject_q) [*8];
    endsequence
    chk_strobe_single: assert property (word_strobe_q
        |=> !word_strobe_q)
        else $error("word strobe longer than one cycle");
    chk_strobe_excl: assert property (!(word_strobe_q && word_reject_q))
        else $error("word both accepted and rejected");
    chk_accept_tracks: assert property (word_strobe_q |-> pos_valid_q)
        else $error("accepted word without tracking");
    chk_pos_on_word: assert property ($changed(pos_frames_q)
        |-> word_pulse)
        else $error("position moved without a word");
    chk_reject_step: assert property (word_reject_q && $past(pos_valid_q)
        |-> pos_frames_q == $past(pos_frames_q) + 24'h000001
        || pos_frames_q == $past(pos_frames_q) - 24'h000001)
        else $error("rejected word did not step position by one");
    chk_err_follows: assert property (word_strobe_q && lock_in
        && $past(lock_in) |-> tc_error_q == {1'b0, pos_frames_q}
        - {1'b0, ref_frames})
        else $error("time code error not updated on accepted word");
    chk_err_hold: assert property (!word_strobe_q
        |-> $stable(tc_error_q))
        else $error("time code error moved without accepted word");
    chk_word_spacing: assert property (word_pulse |=> quiet8)
        else $error("word pulses too close together");
    chk_stall_idle: assert property (idle_q > STALL_CYC + 8
        |-> !code_active_q)
        else $error("code active on a stopped tape");
    chk_fifo_hold: assert property (word_valid && !word_ready
        |=> word_valid && $stable(word_data))
        else $error("fifo head changed while stalled");
    chk_overrun_keep: assert property (overrun_q |=> overrun_q)
        else $error("overrun flag dropped");
endmodule // ltcr_reader_chk

bind ltcr_reader ltcr_reader_chk #(.STALL_CYC(STALL_CYC)) u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .code_in(code_in),
    .lock_in(lock_in), .ref_frames(ref_frames),
    .word_strobe_q(word_strobe_q), .word_reject_q(word_reject_q),
    .pos_frames_q(pos_frames_q), .pos_valid_q(pos_valid_q),
    .tc_error_q(tc_error_q), .code_active_q(code_active_q),
    .overrun_q(overrun_q), .word_valid(word_valid),
    .word_data(word_data), .word_ready(word_ready));
`default_nettype wire

// *** ltcr_tape_model.sv ***
// tape track model: plays one 80-bit word in biphase per request
// assumes requests are raised shortly after a rising clock edge
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// tape model
// ****************************************
module ltcr_tape_model (
    // clock
    input wire logic        clk_sys,
    // word request
    input wire logic        start,
    input wire logic [79:0] word,
    input wire logic        rev,
    input wire logic [15:0] half_cyc,
    // code track and status
    output logic            code_out,
    output logic            busy
);
    int i;
    initial begin
        code_out = 1'b0;
        busy = 1'b0;
    end
    // edge closes each bit, so back-to-back words stay seamless
    always begin
        @(posedge clk_sys iff start);
        #2 busy = 1'b1;
        for (i = 0; i < 80; i++) begin
            repeat (half_cyc) @(posedge clk_sys);
            #2 if (word[rev ? 79 - i : i]) code_out = ~code_out;
            repeat (half_cyc) @(posedge clk_sys);
            #2 code_out = ~code_out;
        end
        busy = 1'b0;
    end
endmodule // ltcr_tape_model
`default_nettype wire

// *** ltcr_reader_bench.sv ***
// self-checking bench for the time code reader and its fifo
// assumes the tape model and bound checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "ltcr_defines.svh"
// ****************************************
// bench top
// ****************************************
module ltcr_reader_bench;
    import ltcr_pkg::*;
    localparam int STALL = 2000;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0;
    logic         code_in, busy, start = 1'b0, rev = 1'b0;
    logic [79:0]  word = '0;
    logic [15:0]  half_cyc = 16'h002c;
    logic         lock_in = 1'b1;
    ltcr_frames_t ref_frames = 24'h00005a;
    logic         word_ready = 1'b0;
    logic         strb, rej, pval, revq, act, ovr, wval;
    ltcr_frames_t pos;
    logic [24:0]  err;
    logic [23:0]  wcyc;
    logic [63:0]  wdata;
    logic [25:0]  evq[$];
    int           miscompares = 0;
    int           cmp_count = 0;

    always #20 clk_sys = ~clk_sys;

    ltcr_reader #(.STALL_CYC(STALL)) u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .code_in(code_in),
        .lock_in(lock_in), .ref_frames(ref_frames),
        .word_strobe_q(strb), .word_reject_q(rej), .pos_frames_q(pos),
        .pos_valid_q(pval), .reverse_q(revq), .tc_error_q(err),
        .word_cycles_q(wcyc), .code_active_q(act), .overrun_q(ovr),
        .word_valid(wval), .word_data(wdata), .word_ready(word_ready));
    ltcr_tape_model u_tape (
        .clk_sys(clk_sys), .start(start), .word(word), .rev(rev),
        .half_cyc(half_cyc), .code_out(code_in), .busy(busy));

    // pulses last a full cycle, so mid-cycle sampling is race free
    always @(negedge clk_sys)
        if (strb === 1'b1 || rej === 1'b1) evq.push_back({strb, revq, pos});

    task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // j counts back from the newest event
    task automatic ev(int j, logic [25:0] exp);
        cmp("word event", {6'h00, exp}, (j < evq.size()) ?
            {6'h00, evq[evq.size() - 1 - j]} : 32'hffffffff);
    endtask
    function automatic logic [79:0] mk_word(int n);
        logic [79:0] w;
        int d[8];
        d = '{n % 30 % 10, n % 30 / 10, n / 30 % 60 % 10, n / 30 % 60 / 10,
              n / 1800 % 60 % 10, n / 1800 % 60 / 10, n / 108000 % 10,
              n / 108000 / 10};
        w = '0;
        for (int k = 0; k < 8; k++) w[8 * k +: 4] = 4'(d[k]);
        w[79:64] = `LTCR_SYNC_FWD;
        return w;
    endfunction
    task automatic send(int n, logic r);
        word = mk_word(n);
        rev = r;
        start = 1'b1;
        @(posedge busy);
        start = 1'b0;
        @(negedge busy);
    endtask
    task automatic settle();
        repeat (8) @(posedge clk_sys);
        #2;
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // two warm-up words train the period, then four contiguous frames
    task automatic test_lock();
        evq.delete();
        send(5000, 1'b0);
        send(7000, 1'b0);
        for (int n = 100; n < 104; n++) send(n, 1'b0);
        settle();
        ev(0, {2'b10, 24'h000067});
        for (int j = 1; j < 4; j++) ev(j, 26'h0000000);
        cmp("tracking", 32'h1, {31'h0, pval});
        cmp("tc error", 32'h0000000d, {7'h00, err});
        cmp("sync spacing", 32'h00001b80, {8'h00, wcyc});
        cmp("code active", 32'h1, {31'h0, act});
        cmp("fifo head", 32'h1, {31'h0, wval});
        cmp("bcd low", 32'h00000313, {16'h0000, wdata[15:0]});
        $display("test lock done");
    endtask
    // one stray word, then a sustained jump; fifo left to fill
    task automatic test_jump();
        evq.delete();
        send(555, 1'b0);
        for (int n = 2000; n < 2004; n++) send(n, 1'b0);
        settle();
        cmp("event count", 32'h5, evq.size());
        ev(4, {2'b00, 24'h000068});
        ev(3, {2'b00, 24'h000069});
        ev(2, {2'b00, 24'h00006a});
        ev(1, {2'b00, 24'h00006b});
        ev(0, {2'b10, 24'h0007d3});
        cmp("tc error", 32'h00000779, {7'h00, err});
        cmp("fifo held", 32'h1, {31'h0, wval});
        cmp("overrun", 32'h0, {31'h0, ovr});
        $display("test jump done");
    endtask
    // slower reverse play while unlocked: a reverse word lags one sync
    task automatic test_rev();
        half_cyc = 16'h0030;
        lock_in = 1'b0;
        evq.delete();
        send(2002, 1'b1);
        send(2001, 1'b1);
        settle();
        cmp("reverse events", 32'h1, evq.size());
        ev(0, {2'b11, 24'h0007d2});
        cmp("reverse", 32'h1, {31'h0, revq});
        cmp("unlocked error", 32'h00000779, {7'h00, err});
        lock_in = 1'b1;
        $display("test reverse done");
    endtask
    task automatic test_stall();
        evq.delete();
        repeat (STALL + 50) @(posedge clk_sys);
        cmp("code active", 32'h0, {31'h0, act});
        cmp("stopped words", 32'h0, evq.size());
        $display("test stall done");
    endtask
    // drain the accepted words held since the lock, one handshake each
    task automatic test_fifo();
        logic [31:0] want [3];
        int n;
        want = '{32'h00000313, 32'h00010623, 32'h00010622};
        n = 0;
        for (int k = 0; k < 8; k++) begin
            @(posedge clk_sys);
            #2;
            if (wval === 1'b1 && n < 3) begin
                cmp("fifo data", want[n], wdata[31:0]);
                cmp("user bits", 32'h0, wdata[63:32]);
                n++;
                word_ready = 1'b1;
                @(posedge clk_sys);
                #2 word_ready = 1'b0;
            end
        end
        cmp("fifo drain", 32'h3, n);
        cmp("fifo empty", 32'h0, {31'h0, wval});
        cmp("overrun", 32'h0, {31'h0, ovr});
        $display("test fifo done");
    endtask

    initial begin
        repeat (2) @(posedge clk_sys);
        #2 rst_n = 1'b1;
        test_lock();
        test_jump();
        test_rev();
        test_fifo();
        test_stall();
        finish_test();
    end
    initial begin
        repeat (99000) @(posedge clk_sys);
        miscompares++;
        finish_test();
    end
endmodule // ltcr_reader_bench
`default_nettype wire
